// *** cap_regs_pkg.sv ***
// Offsets, field positions and reset values of the capability words.
`default_nettype none
package cap_regs_pkg;
  localparam logic [7:0] CAP_LEN_OFFSET = 8'h00;
  localparam logic [7:0] STRUCT_OFFSET = 8'h04;
  localparam int CAP_LEN_LSB = 0;
  localparam int VERSION_LSB = 16;
  localparam int DEBUG_PORT_LSB = 20;
  localparam int INDICATOR_BIT = 16;
  localparam int COMPANION_LSB = 12;
  localparam int PER_COMPANION_LSB = 8;
  localparam int ROUTING_BIT = 7;
  localparam int POWER_SWITCH_BIT = 4;
  localparam int PORT_COUNT_LSB = 0;
  localparam logic [7:0] CAP_LEN_RESET = 8'h20;
  localparam logic [15:0] VERSION_RESET = 16'h0100;
  localparam logic [3:0] DEBUG_PORT_RESET = 4'h0;
  localparam logic [3:0] COMPANION_RESET = 4'h2;
  localparam logic [3:0] PER_COMPANION_RESET = 4'h2;
  localparam logic ROUTING_RESET = 1'b1;
  localparam logic POWER_SWITCH_RESET = 1'b1;
  localparam logic [3:0] PORT_COUNT_RESET = 4'h4;
endpackage
`default_nettype wire

// *** hs_host_capability_regs.sv ***
// Read-only capability register bank at the bottom of the register window.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Operation
// R01: Capability words sit at the lowest offsets, before operational space.
// R02: Offset zero returns length in 7:0, zeros in 15:8, version in 31:16.
// R03: Length is in bytes; software adds it to base for operational space.
// R04: Version is BCD 16 bits, reset value 0100h meaning 1.00.
// R05: Offset four returns structural word; bits 31:24 and 19:17 read zero.
// R06: Bits 23:20 name the debug port; zero means none, reset zero.
// R07: Debug port number never exceeds reported port count.
// R08: Reset: 2 companions, 2 ports each, routing 1, power switch 1, 4 ports.
// R09: Bit 16 loads from indicator strap sampled during reset; here caught on first edge after release.
// R10: Port count gives downstream ports; valid 1h to Fh, zero undefined.
// R11: Writes are ignored, fields unchanged, and reads have no side effect.
module hs_host_capability_regs
  import cap_regs_pkg::*;
#(
  parameter logic [3:0] PORT_COUNT = PORT_COUNT_RESET,
  parameter logic [3:0] DEBUG_PORT = DEBUG_PORT_RESET,
  parameter logic [7:0] CAP_LENGTH = CAP_LEN_RESET
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic indicator_strap_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_hit
);

  // Refuse configurations that break R10, R07 or R01.
  if (PORT_COUNT == 4'h0) // [R10]
  begin : g_bad_ports
    $error("Port count must be 1 to 15.");
  end
  if (DEBUG_PORT > PORT_COUNT) // [R07]
  begin : g_bad_debug
    $error("Debug port beyond port count.");
  end
  if (CAP_LENGTH < 8'h08) // [R01]
  begin : g_bad_len
    $error("Capability region must cover both words.");
  end

  typedef struct packed {
    logic in_reset;
    logic indicator;
    logic [31:0] rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [31:0] cap_word;
  logic [31:0] struct_word;

  function automatic logic [31:0] field4(input logic [3:0] v, input int lsb);
    field4 = 32'(v) << lsb;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cap_word = 32'h0000_0000;
    cap_word |= 32'(VERSION_RESET) << VERSION_LSB; // [R02] [R04]
    cap_word |= 32'(CAP_LENGTH) << CAP_LEN_LSB; // [R02] [R03]
    struct_word = 32'h0000_0000; // [R05]
    struct_word |= field4(DEBUG_PORT, DEBUG_PORT_LSB); // [R06] [R07]
    struct_word[INDICATOR_BIT] = state_reg.indicator; // [R09]
    struct_word |= field4(COMPANION_RESET, COMPANION_LSB); // [R08]
    struct_word |= field4(PER_COMPANION_RESET, PER_COMPANION_LSB); // [R08]
    struct_word[ROUTING_BIT] = ROUTING_RESET; // [R08]
    struct_word[POWER_SWITCH_BIT] = POWER_SWITCH_RESET; // [R08]
    struct_word |= field4(PORT_COUNT, PORT_COUNT_LSB); // [R08] [R10]
  end

  // The strap is caught on the first edge after reset release, since an
  // asynchronous reset may only load constants.
  always_comb
  begin
    state_next = state_reg;
    state_next.in_reset = 1'b0;
    if (state_reg.in_reset)
    begin
      state_next.indicator = indicator_strap_pin; // [R09]
    end
    // Writes fall through untouched; a read only refreshes the data output.
    if (reg_addr == CAP_LEN_OFFSET) // [R01]
    begin
      state_next.rdata = cap_word;
    end
    else if (reg_addr == STRUCT_OFFSET)
    begin
      state_next.rdata = struct_word;
    end
    else
    begin
      state_next.rdata = 32'h0000_0000;
    end
    if (!reg_rd) // [R11]
    begin
      state_next.rdata = state_reg.rdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= '{in_reset: 1'b1, indicator: 1'b0, rdata: 32'h0000_0000};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign reg_hit = (reg_addr == CAP_LEN_OFFSET) || (reg_addr == STRUCT_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  property p_cap_read;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == CAP_LEN_OFFSET) |=>
      (reg_rdata[15:8] == 8'h00 && reg_rdata[31:16] == 16'h0100);
  endproperty
  a_cap_read: assert property (p_cap_read) // [R02]
    else $error("Bad version word.");

  property p_len;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == CAP_LEN_OFFSET) |=> reg_rdata[7:0] == CAP_LENGTH;
  endproperty
  a_len: assert property (p_len) // [R03]
    else $error("Bad length.");

  property p_version;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == CAP_LEN_OFFSET) |=> reg_rdata[31:16] == 16'h0100;
  endproperty
  a_version: assert property (p_version) // [R04]
    else $error("Bad version.");

  property p_reserved;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == STRUCT_OFFSET) |=>
      (reg_rdata[31:24] == 8'h00 && reg_rdata[19:17] == 3'h0
       && reg_rdata[6:5] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) // [R05]
    else $error("Reserved set.");

  property p_debug;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == STRUCT_OFFSET) |=>
      (reg_rdata[23:20] <= reg_rdata[3:0] && reg_rdata[23:20] == DEBUG_PORT);
  endproperty
  a_debug: assert property (p_debug) // [R06] [R07]
    else $error("Debug port bad.");

  property p_struct;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == STRUCT_OFFSET) |=>
      (reg_rdata[15:7] == 9'h045 && reg_rdata[4] && reg_rdata[3:0] != 4'h0);
  endproperty
  a_struct: assert property (p_struct) // [R08] [R10]
    else $error("Structural bad.");

  property p_strap;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == STRUCT_OFFSET && !$past(state_reg.in_reset)) |=>
      reg_rdata[16] == $past(state_reg.indicator);
  endproperty
  a_strap: assert property (p_strap) // [R09]
    else $error("Indicator bad.");

  // The reset edge itself still loads constants, so the capture is only
  // checked once reset has been seen released.
  property p_strap_capture;
    @(posedge clk) disable iff (!arst_n)
    (arst_n && state_reg.in_reset) |=>
      state_reg.indicator == $past(indicator_strap_pin);
  endproperty
  a_strap_capture: assert property (p_strap_capture) // [R09]
    else $error("Strap not captured.");

  // Later moves of the strap pin must never reach the reported bit.
  property p_strap_keep;
    @(posedge clk) disable iff (!arst_n)
    (!state_reg.in_reset) |=> $stable(state_reg.indicator);
  endproperty
  a_strap_keep: assert property (p_strap_keep) // [R09]
    else $error("Indicator moved.");

  property p_hold;
    @(posedge clk) disable iff (!arst_n)
    (!reg_rd) |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) // [R11]
    else $error("Data moved.");

  property p_write_ignored;
    @(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_rd && reg_addr == STRUCT_OFFSET) |=>
      (reg_rdata[15:4] == 12'h229 && reg_rdata[3:0] == PORT_COUNT);
  endproperty
  a_write_ignored: assert property (p_write_ignored) // [R11]
    else $error("Write reached a field.");

  property p_first;
    @(posedge clk) disable iff (!arst_n)
    reg_hit |-> reg_addr < CAP_LENGTH;
  endproperty
  a_first: assert property (p_first) // [R01]
    else $error("Outside region.");

  c_cap: cover property (@(posedge clk) reg_rd && reg_addr == CAP_LEN_OFFSET);
  c_struct: cover property (@(posedge clk)
    reg_rd && reg_addr == STRUCT_OFFSET);
  c_write: cover property (@(posedge clk) reg_wr && reg_hit);
  c_miss: cover property (@(posedge clk) reg_rd && !reg_hit);
  c_write_data: cover property (@(posedge clk)
    reg_wr && reg_hit && reg_wdata != 32'h0000_0000);

endmodule

`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the capability register bank.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cap_regs_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic indicator_strap_pin = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_hit;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] a;
  logic [7:0] corner [7] = '{8'h00, 8'h04, 8'h01, 8'h08,
                             8'hFF, 8'h04, 8'h00};

  hs_host_capability_regs hs_host_capability_regs_i (
    .clk(clk),
    .arst_n(arst_n),
    .indicator_strap_pin(indicator_strap_pin),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The expected words are built field by field, not from the package.
  function automatic logic [31:0] exp_word(input logic [7:0] ad,
                                           input logic s);
    if (ad == 8'h00)
      return {16'h0100, 8'h00, 8'h20};
    if (ad == 8'h04)
      return {8'h00, 4'h0, 3'h0, s, 4'h2, 4'h2, 1'b1, 2'h0, 1'b1, 4'h4};
    return 32'h0000_0000;
  endfunction

  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read strobe stays high between reads, so reads run back to back.
  // A write strobe, set at random, rides along with each read and must change nothing.
  task automatic rd(input logic [7:0] ad, input logic s);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    reg_wr <= 1'($urandom);
    reg_wdata <= $urandom;
    #1 check_bit(reg_hit, ad == 8'h00 || ad == 8'h04);
    @(posedge clk);
    #1 check_word(reg_rdata, exp_word(ad, s));
    if (ad == 8'h04)
    begin
      check_bit(reg_rdata[23:20] <= reg_rdata[3:0], 1'b1);
      check_bit(|reg_rdata[3:0], 1'b1);
      check_word(32'(reg_rdata[15:0]), 32'h0000_2294);
    end
  endtask

  // With the strobe low a write must neither land nor disturb the data.
  task automatic wr_only(input logic [7:0] ad, input logic s);
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= 8'h04;
    reg_wdata <= $urandom;
    repeat (3) @(posedge clk);
    #1 check_word(reg_rdata, exp_word(ad, s));
  endtask

  // The strap flips after capture; the reported bit must not follow it.
  task automatic do_reset(input logic s);
    @(posedge clk);
    arst_n <= 1'b0;
    reg_rd <= 1'b0;
    indicator_strap_pin <= s;
    repeat (5) @(posedge clk);
    #1 check_word(reg_rdata, 32'h0000_0000);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    indicator_strap_pin <= ~s;
  endtask

  initial
  begin
    void'($urandom(75));
    for (int r = 0; r < 2; r++)
    begin
      do_reset(r[0]);
      foreach (corner[i])
        rd(corner[i], r[0]);
      wr_only(8'h00, r[0]);
      repeat (40)
      begin
        a = 8'($urandom);
        if (a[7])
          a = {5'h00, a[0], 2'h0};
        rd(a, r[0]);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
